// File: design/iot_defines.svh
`ifndef IOT_DEFINES_SVH
`define IOT_DEFINES_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define IOT_OFS_STATUS   8'h00
`define IOT_OFS_MASK     8'h04
`define IOT_OFS_RELOAD   8'h08
`define IOT_OFS_CAPTURE  8'h0c
`define IOT_OFS_T2CTL    8'hc8
`define IOT_OFS_IOCTL    8'hf8

// ****************************************
// Field positions and reset values
// ****************************************
`define IOT_IO_FLOAT     0
`define IOT_IO_HZ_BASE   1
`define IOT_IO_PULL      4
`define IOT_IO_RXERR     5
`define IOT_IO_CHAIN     6
`define IOT_IO_RSVD      7
`define IOT_IO_WMASK     8'h5f
`define IOT_T2_CPRL      0
`define IOT_T2_SRC       1
`define IOT_T2_RUN       2
`define IOT_T2_EXEN      3
`define IOT_T2_SERIAL_TX_CLOCK_SELECT      4
`define IOT_T2_RCLK      5
`define IOT_T2_WMASK     8'h3f
`define IOT_RST_BYTE     8'h00
`define IOT_RST_HALF     16'h0000
`define IOT_RST_WORD     32'h0000_0000

// ****************************************
// Crystal dividers
// ****************************************
`define IOT_DIV_TIMER    4'hc
`define IOT_DIV_BAUD     4'h2

`endif

// File: design/iot_pkg.sv
package iot_pkg;

  // ****************************************
  // Event carrier, one bit per sticky status flag
  // ****************************************
  typedef struct packed {
    logic ext_trigger;
    logic t2_overflow;
    logic chain_carry;
    logic rx_error;
  } iot_evt_t;

endpackage : iot_pkg

// File: design/iot_ctrl.sv
`timescale 1ns/10ps
`include "iot_defines.svh"
// How it works
// [R1] Float bit clear keeps ports driving; set floats them in any power-down.
// [R2] Each high-impedance bit turns port one, two or three into an input.
// [R3] Chain bit joins timers zero and one; its carry sets timer one overflow.
// [R4] The top bit of port control always reads zero; software writes zero.
// [R5] Clock-source bit picks crystal divided by 12 or 2, or the pin.
// [R6] Timer two counts while its run bit is one, holds otherwise; an enabled external reload still loads it while the run bit is zero.
// [R7] Timer two external control input is ignored unless its enable bit is set.
// [R8] Transmit clock select bit chooses the serial transmit clock source.
// [R9] Overrun or framing error sets the receive error flag until software clears.
// [R10] Capture or reload select applies only when no serial clock bit is set.
module iot_ctrl
  import iot_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Core status
  input  wire logic              soft_power_down,
  input  wire logic              hard_power_down,
  input  wire logic              rx_overrun,
  input  wire logic              rx_framing,
  input  wire logic              timer_one_run,
  input  wire logic              timer_one_carry,
  input  wire logic              timer_one_overflow_clr,
  // Pins
  input  wire logic              timer_two_count_in,
  input  wire logic              timer_two_ext_control_in,
  // Controls out
  output logic [3:0]             port_out_en,
  output logic                   strong_pullup_off,
  output logic                   timer_one_overflow,
  output logic                   serial_tx_clock,
  output logic                   irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0]  io_port_control_q;
  logic [7:0]  timer_two_control_q;
  logic [3:0]  status_q;
  logic [3:0]  mask_q;
  logic [15:0] reload_q;
  logic [15:0] capture_q;
  logic [15:0] count_q;
  logic [31:0] chain_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        access;
  logic        wr;
  logic        hit;
  logic [31:0] rd_d;

  assign access = psel && penable && !pready_q;
  assign wr     = psel && penable && pready_q && pwrite;

  always_comb begin
    hit  = 1'b1;
    rd_d = `IOT_RST_WORD;
    unique case (paddr)
      `IOT_OFS_STATUS:  rd_d[3:0] = status_q;
      `IOT_OFS_MASK:    rd_d[3:0] = mask_q;
      `IOT_OFS_RELOAD:  rd_d[15:0] = reload_q;
      `IOT_OFS_CAPTURE: rd_d[15:0] = capture_q;
      `IOT_OFS_T2CTL:   rd_d[7:0] = timer_two_control_q;
      `IOT_OFS_IOCTL:   rd_d[7:0] = io_port_control_q & ~(8'h01 << `IOT_IO_RSVD); // R4
      default:          hit = 1'b0;
    endcase
  end

  // One wait state: data is registered on the same edge that pready rises.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= `IOT_RST_WORD;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !hit;
      if (access && !pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] cnt_sync_q;
  logic [2:0] ext_sync_q;
  logic       cnt_lvl_q;
  logic       ext_lvl_q;
  logic       cnt_fall;
  logic       ext_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
      cnt_lvl_q  <= 1'b0;
      ext_lvl_q  <= 1'b0;
    end else begin
      cnt_sync_q <= {cnt_sync_q[1:0], timer_two_count_in};
      ext_sync_q <= {ext_sync_q[1:0], timer_two_ext_control_in};
      if (cnt_sync_q[1] == cnt_sync_q[2]) begin
        cnt_lvl_q <= cnt_sync_q[2];
      end
      if (ext_sync_q[1] == ext_sync_q[2]) begin
        ext_lvl_q <= ext_sync_q[2];
      end
    end
  end

  // Both pins act on a filtered falling edge.
  assign cnt_fall = cnt_lvl_q && (cnt_sync_q[1] == cnt_sync_q[2]) && !cnt_sync_q[2];
  assign ext_fall = ext_lvl_q && (ext_sync_q[1] == ext_sync_q[2]) && !ext_sync_q[2];

  // ****************************************
  // Crystal prescaler
  // ****************************************
  logic [3:0] div12_q;
  logic [3:0] div2_q;
  logic       tick12;
  logic       tick2;

  assign tick12 = (div12_q == `IOT_DIV_TIMER - 4'h1);
  assign tick2  = (div2_q == `IOT_DIV_BAUD - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_q <= 4'h0;
      div2_q  <= 4'h0;
    end else begin
      div12_q <= tick12 ? 4'h0 : div12_q + 4'h1;
      div2_q  <= tick2 ? 4'h0 : div2_q + 4'h1;
    end
  end

  // ****************************************
  // Timer two
  // ****************************************
  logic baud_mode;
  logic capture_mode;
  logic t2_tick;
  logic t2_step;
  logic t2_wrap;
  logic ext_trig;

  assign baud_mode    = timer_two_control_q[`IOT_T2_SERIAL_TX_CLOCK_SELECT] || timer_two_control_q[`IOT_T2_RCLK];
  assign capture_mode = timer_two_control_q[`IOT_T2_CPRL] && !baud_mode; // R10
  // Baud generation runs the crystal at divide by 2, otherwise by 12.
  assign t2_tick = timer_two_control_q[`IOT_T2_SRC] ? cnt_fall
                 : (baud_mode ? tick2 : tick12); // R5
  assign t2_step = timer_two_control_q[`IOT_T2_RUN] && t2_tick; // R6
  assign t2_wrap = t2_step && (count_q == 16'hffff);
  assign ext_trig = timer_two_control_q[`IOT_T2_EXEN] && ext_fall; // R7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `IOT_RST_HALF;
    end else if (ext_trig && !capture_mode && !baud_mode) begin
      count_q <= reload_q; // R10
    end else if (t2_wrap) begin
      count_q <= capture_mode ? `IOT_RST_HALF : reload_q;
    end else if (t2_step) begin
      count_q <= count_q + 16'h0001; // R6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= `IOT_RST_HALF;
    end else if (ext_trig && capture_mode) begin
      capture_q <= count_q; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= `IOT_RST_HALF;
    end else if (wr && paddr == `IOT_OFS_RELOAD) begin
      reload_q <= pwdata[15:0];
    end
  end

  // ****************************************
  // Chained 32-bit counter
  // ****************************************
  logic chain_step;
  logic chain_carry;

  assign chain_step  = io_port_control_q[`IOT_IO_CHAIN] && timer_one_run && tick12;
  assign chain_carry = chain_step && (chain_q == 32'hffff_ffff); // R3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_q <= `IOT_RST_WORD;
    end else if (chain_step) begin
      chain_q <= chain_q + 32'h0000_0001; // R3
    end
  end

  // Set wins over the core's clear so no carry is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_one_overflow <= 1'b0;
    end else if (chain_carry) begin
      timer_one_overflow <= 1'b1; // R3
    end else if (timer_one_overflow_clr) begin
      timer_one_overflow <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic rx_err;
  assign rx_err = rx_overrun || rx_framing;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_port_control_q <= `IOT_RST_BYTE;
    end else begin
      if (wr && paddr == `IOT_OFS_IOCTL) begin
        io_port_control_q <= pwdata[7:0] & `IOT_IO_WMASK; // R4
        io_port_control_q[`IOT_IO_RXERR] <= io_port_control_q[`IOT_IO_RXERR]
                                           && pwdata[`IOT_IO_RXERR]; // R9
      end
      if (rx_err) begin
        io_port_control_q[`IOT_IO_RXERR] <= 1'b1; // R9
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_two_control_q <= `IOT_RST_BYTE;
    end else if (wr && paddr == `IOT_OFS_T2CTL) begin
      timer_two_control_q <= pwdata[7:0] & `IOT_T2_WMASK;
    end
  end

  // ****************************************
  // Port drive control
  // ****************************************
  logic powered_down;
  assign powered_down = soft_power_down || hard_power_down;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out_en[0] <= 1'b1;
    end else begin
      port_out_en[0] <= !(io_port_control_q[`IOT_IO_FLOAT] && powered_down); // R1
    end
  end

  for (genvar g = 1; g < 4; g++) begin : g_port
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        port_out_en[g] <= 1'b1;
      end else begin
        port_out_en[g] <= !(io_port_control_q[`IOT_IO_FLOAT] && powered_down)
                          && !io_port_control_q[`IOT_IO_HZ_BASE + g - 1]; // R1 R2
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strong_pullup_off <= 1'b0;
    end else begin
      strong_pullup_off <= io_port_control_q[`IOT_IO_PULL];
    end
  end

  // The transmit clock is a one-cycle overflow pulse, not a square wave.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_tx_clock <= 1'b0;
    end else begin
      serial_tx_clock <= timer_two_control_q[`IOT_T2_SERIAL_TX_CLOCK_SELECT] ? t2_wrap
                                                           : timer_one_carry; // R8
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  iot_evt_t evt;
  assign evt = '{ext_trigger: ext_trig, t2_overflow: t2_wrap,
                 chain_carry: chain_carry, rx_error: rx_err};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 4'h0;
      mask_q   <= 4'h0;
      irq      <= 1'b0;
    end else begin
      if (wr && paddr == `IOT_OFS_MASK) begin
        mask_q <= pwdata[3:0];
      end
      if (wr && paddr == `IOT_OFS_STATUS) begin
        status_q <= (status_q & ~pwdata[3:0]) | evt;
      end else begin
        status_q <= status_q | evt;
      end
      irq <= |(status_q & mask_q);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FLOAT_OFF: assert property ((io_port_control_q[`IOT_IO_FLOAT] && powered_down)
    |=> port_out_en == 4'h0) else $error("ports still drive in power-down float"); // R1
  AST_FLOAT_HOLD: assert property (!io_port_control_q[`IOT_IO_FLOAT]
    |=> port_out_en[0]) else $error("port zero left output mode"); // R1
  AST_HIGH_Z: assert property (io_port_control_q[`IOT_IO_HZ_BASE + 1]
    |=> !port_out_en[2]) else $error("port two not high impedance"); // R2
  AST_CHAIN_CARRY: assert property (chain_step && chain_q == 32'hffff_ffff
    |=> timer_one_overflow && chain_q == 32'h0) else $error("chain carry lost"); // R3
  AST_RSVD_ZERO: assert property (access && !pwrite && paddr == `IOT_OFS_IOCTL
    |=> pready && !prdata[`IOT_IO_RSVD]) else $error("reserved bit read as one"); // R4
  AST_INT_SOURCE: assert property (timer_two_control_q[`IOT_T2_RUN]
    && !timer_two_control_q[`IOT_T2_SRC] && !baud_mode && !ext_trig && tick12
    && count_q != 16'hffff |=> count_q == $past(count_q) + 16'h0001)
    else $error("timer two missed crystal tick"); // R5
  AST_STOPPED: assert property (!timer_two_control_q[`IOT_T2_RUN] && !ext_trig
    |=> $stable(count_q)) else $error("timer two moved while stopped"); // R6
  AST_EXT_IGNORED: assert property (!timer_two_control_q[`IOT_T2_EXEN]
    |=> $stable(capture_q)) else $error("external input not ignored"); // R7
  AST_TX_CLOCK: assert property (timer_two_control_q[`IOT_T2_SERIAL_TX_CLOCK_SELECT] && t2_wrap
    |=> serial_tx_clock) else $error("transmit clock not from timer two"); // R8
  AST_RX_STICKY: assert property (io_port_control_q[`IOT_IO_RXERR]
    && !(wr && paddr == `IOT_OFS_IOCTL)
    |=> io_port_control_q[`IOT_IO_RXERR]) else $error("receive error flag dropped"); // R9
  AST_BAUD_NO_CAPTURE: assert property (baud_mode |=> $stable(capture_q))
    else $error("capture taken in baud mode"); // R10

  COV_CAPTURE: cover property (ext_trig && capture_mode);
  COV_CHAIN: cover property (chain_carry);
  COV_IRQ: cover property (!irq ##1 irq);

endmodule : iot_ctrl

// File: verif/iot_ctrl_tb.sv
`timescale 1ns/10ps
`include "iot_defines.svh"
module iot_ctrl_tb;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        soft_power_down;
  logic        hard_power_down;
  logic        rx_overrun;
  logic        rx_framing;
  logic        timer_one_run;
  logic        timer_one_carry;
  logic        timer_one_overflow_clr;
  logic        timer_two_count_in;
  logic        timer_two_ext_control_in;
  logic [3:0]  port_out_en;
  logic        strong_pullup_off;
  logic        timer_one_overflow;
  logic        serial_tx_clock;
  logic        irq;
  logic [31:0] rdata;
  logic        rerr;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          tx_pulses = 0;
  int          fell_at;
  int          k;

  iot_ctrl u_iot_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .soft_power_down(soft_power_down), .hard_power_down(hard_power_down),
    .rx_overrun(rx_overrun), .rx_framing(rx_framing), .timer_one_run(timer_one_run),
    .timer_one_carry(timer_one_carry), .timer_one_overflow_clr(timer_one_overflow_clr),
    .timer_two_count_in(timer_two_count_in),
    .timer_two_ext_control_in(timer_two_ext_control_in), .port_out_en(port_out_en),
    .strong_pullup_off(strong_pullup_off), .timer_one_overflow(timer_one_overflow),
    .serial_tx_clock(serial_tx_clock), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // The ceiling is many times the expected run, so only a hang reaches it.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (serial_tx_clock === 1'b1) tx_pulses <= tx_pulses + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdata = prdata;
    rerr = pslverr;
    // A slave that never answers ends the run here rather than later transfers.
    if (n >= 40) begin
      chk("pready", 32'h1, 32'h0);
      summarize;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdata);
  endtask : rd

  // Pins pass a three-stage synchroniser, so each level is held five cycles.
  task pin_edge(input int w);
    if (w == 0) timer_two_count_in <= 1'b0;
    else timer_two_ext_control_in <= 1'b0;
    fell_at = cyc;
    repeat (5) @(posedge pclk);
    if (w == 0) timer_two_count_in <= 1'b1;
    else timer_two_ext_control_in <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask : pin_edge

  task port_en(input logic [3:0] exp);
    repeat (3) @(posedge pclk);
    chk("port_out_en", {28'h0, exp}, {28'h0, port_out_en});
  endtask : port_en

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    chk("port_out_en", 32'hf, {28'h0, port_out_en});
    rd("ioctl", `IOT_OFS_IOCTL, 32'h0);
    rd("t2ctl", `IOT_OFS_T2CTL, 32'h0);
    rd("status", `IOT_OFS_STATUS, 32'h0);
    rd("mask", `IOT_OFS_MASK, 32'h0);
  endtask : t_reset

  task t_ports;
    wr(`IOT_OFS_IOCTL, 32'hff);
    rd("ioctl", `IOT_OFS_IOCTL, 32'h5f);
    port_en(4'h1);
    chk("pullup", 32'h1, {31'h0, strong_pullup_off});
    for (k = 0; k < 2; k++) begin
      if (k == 0) soft_power_down <= 1'b1;
      else hard_power_down <= 1'b1;
      port_en(4'h0);
      soft_power_down <= 1'b0;
      hard_power_down <= 1'b0;
      port_en(4'h1);
    end
    wr(`IOT_OFS_IOCTL, 32'h0e);
    soft_power_down <= 1'b1;
    port_en(4'h1);
    wr(`IOT_OFS_IOCTL, 32'h00);
    port_en(4'hf);
    soft_power_down <= 1'b0;
  endtask : t_ports

  task t_rx_irq;
    for (k = 0; k < 2; k++) begin
      if (k == 0) rx_overrun <= 1'b1;
      else rx_framing <= 1'b1;
      @(posedge pclk);
      rx_overrun <= 1'b0;
      rx_framing <= 1'b0;
      repeat (2) @(posedge pclk);
      rd("rxerr", `IOT_OFS_IOCTL, 32'h20);
      wr(`IOT_OFS_IOCTL, 32'h20);
      rd("rxerr", `IOT_OFS_IOCTL, 32'h20);
      wr(`IOT_OFS_IOCTL, 32'h00);
      rd("rxerr", `IOT_OFS_IOCTL, 32'h00);
    end
    rd("status", `IOT_OFS_STATUS, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    // The interrupt is registered from the mask, so it settles one edge after the write.
    wr(`IOT_OFS_MASK, 32'h1);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`IOT_OFS_MASK, 32'h0);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`IOT_OFS_MASK, 32'h1);
    wr(`IOT_OFS_STATUS, 32'h1);
    rd("status", `IOT_OFS_STATUS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    rd("unmapped", 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
  endtask : t_rx_irq

  task t_timer;
    wr(`IOT_OFS_RELOAD, 32'hfffd);
    wr(`IOT_OFS_T2CTL, 32'h0e);
    rd("t2ctl", `IOT_OFS_T2CTL, 32'h0e);
    pin_edge(1);
    pin_edge(0);
    pin_edge(0);
    rd("status", `IOT_OFS_STATUS, 32'h8);
    pin_edge(0);
    rd("status", `IOT_OFS_STATUS, 32'hc);
    wr(`IOT_OFS_STATUS, 32'hf);
    wr(`IOT_OFS_T2CTL, 32'h0f);
    pin_edge(0);
    pin_edge(0);
    pin_edge(1);
    rd("capture", `IOT_OFS_CAPTURE, 32'hffff);
    wr(`IOT_OFS_T2CTL, 32'h0b);
    repeat (3) pin_edge(0);
    pin_edge(1);
    rd("capture", `IOT_OFS_CAPTURE, 32'hffff);
    wr(`IOT_OFS_T2CTL, 32'h07);
    wr(`IOT_OFS_STATUS, 32'hf);
    pin_edge(0);
    pin_edge(1);
    rd("status", `IOT_OFS_STATUS, 32'h4);
    rd("capture", `IOT_OFS_CAPTURE, 32'hffff);
    wr(`IOT_OFS_T2CTL, 32'h0f);
    pin_edge(1);
    rd("capture", `IOT_OFS_CAPTURE, 32'h0);
    wr(`IOT_OFS_RELOAD, 32'hfffe);
    wr(`IOT_OFS_T2CTL, 32'h0e);
    pin_edge(1);
    wr(`IOT_OFS_T2CTL, 32'h1f);
    k = tx_pulses;
    pin_edge(0);
    pin_edge(0);
    chk("txclk", 32'h1, 32'(tx_pulses - k));
    wr(`IOT_OFS_T2CTL, 32'h0f);
    pin_edge(1);
    rd("capture", `IOT_OFS_CAPTURE, 32'hfffe);
    wr(`IOT_OFS_T2CTL, 32'h2f);
    pin_edge(1);
    rd("capture", `IOT_OFS_CAPTURE, 32'hfffe);
  endtask : t_timer

  // Ten ticks of the crystal divided by 12 fall into any 120-cycle window.
  task t_rate;
    logic [15:0] a0;
    int          t0;
    wr(`IOT_OFS_T2CTL, 32'h00);
    k = tx_pulses;
    timer_one_carry <= 1'b1;
    @(posedge pclk);
    timer_one_carry <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("txclk", 32'h1, 32'(tx_pulses - k));
    wr(`IOT_OFS_T2CTL, 32'h09);
    repeat (30) @(posedge pclk);
    pin_edge(1);
    rd("capture", `IOT_OFS_CAPTURE, 32'hfffe);
    wr(`IOT_OFS_T2CTL, 32'h0d);
    pin_edge(1);
    t0 = fell_at;
    apb(1'b0, `IOT_OFS_CAPTURE, 32'h0000_0000);
    a0 = rdata[15:0];
    while (cyc != t0 + 120) @(posedge pclk);
    pin_edge(1);
    rd("capture", `IOT_OFS_CAPTURE, {16'h0, a0 + 16'h000a});
    chk("chain_ovf", 32'h0, {31'h0, timer_one_overflow});
  endtask : t_rate

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    soft_power_down = 1'b0;
    hard_power_down = 1'b0;
    rx_overrun = 1'b0;
    rx_framing = 1'b0;
    timer_one_run = 1'b0;
    timer_one_carry = 1'b0;
    timer_one_overflow_clr = 1'b0;
    timer_two_count_in = 1'b1;
    timer_two_ext_control_in = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_ports;
    t_rx_irq;
    t_timer;
    t_rate;
    summarize;
  end
endmodule : iot_ctrl_tb
